// ==== hdl/asc_scan_top.sv ====
`timescale 1ns/1ps
`include "asc_regs.svh"
// Summary of operation
// - One converter; selector steps channels, reference, junction.
// - Converter resolution programmable 16 to 24 bits.
// - Each channel converted at its own resolution.
// - Latest corrected values rewritten to memory continuously.
// - Master reads memory anytime, even during writes.
// - Flag under range, over range, open input.
// - Open detect covers any wire or cable.
// - One cold junction shared, unless remote channel.
// - Switch gives bus address or diagnostics.
// - Flash red while powering up.
// - Dark after self-test until configured.
// - Steady green once configured and running.
// - Blink green when master enters configure.
// - Blink green when expander bus lost.
// - Steady red after fatal module failure.
// - Steady red on power fail interrupt.
// - Diagnostic mode shows pass or fail.
// - Calibrate continuously against system reference.
// - Apply corrections before storing each value.
// - Background integrity checks during scanning.
// - Twelve line synchronous parallel bus exchange.
// - Per channel status shows hardware, config errors.
module asc_scan_top #(
    parameter int unsigned BLINK_CYCLES =
        `ASC_BLINK_MS * `ASC_US_PER_MS * `ASC_CLK_MHZ,
    parameter int unsigned TMO_CYCLES =
        `ASC_TMO_MS * `ASC_US_PER_MS * `ASC_CLK_MHZ
) (
    input wire logic core_clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic [7:0] addr_switch, // Address switch pins
    input wire logic pfi_pin, // Power fail interrupt pin
    input wire logic bus_lost_pin, // Expander watchdog lost
    input wire logic cable_absent_pin, // Termination cable off
    input wire logic [15:0] open_pin, // Per channel open wire
    input wire logic cfg_download, // Configuration written
    input wire logic master_execute, // Master in execute mode
    input wire logic res_wr_en, // Resolution write strobe
    input wire logic [3:0] res_wr_chan, // Channel to set
    input wire logic [2:0] res_wr_code, // 0..4 = 16..24 bits
    input wire logic [15:0] tc_mask, // Thermocouple channels
    input wire logic cj_remote_en, // Remote junction in use
    input wire logic [3:0] cj_remote_chan, // Remote junction channel
    input wire logic adc_done, // Conversion finished
    input wire asc_pkg::asc_val_t adc_data, // Conversion result
    output logic adc_start, // Start pulse
    output logic [4:0] adc_sel, // Input selector slot
    output logic [2:0] adc_res, // Resolution code
    input wire logic mem_rd_en, // Master read strobe
    input wire logic [3:0] mem_rd_addr, // Master read channel
    output asc_pkg::asc_word_t mem_rd_data, // Value and status
    output logic mem_rd_valid, // Read data valid
    output logic [7:0] slave_addr, // Expander bus address
    output logic diag_mode, // Stand-alone diagnostics
    output logic fatal, // Fatal failure latched
    output logic led_red, // Red lamp
    output logic led_green // Green lamp
);
    import asc_pkg::*;
    localparam logic [27:0] TMO_LIM = 28'(TMO_CYCLES);

    logic [7:0] sw_s;
    logic pfi_s, lost_s, cab_s;
    logic [15:0] open_s;

    asc_sync #(.W(`ASC_SYNC_W)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .d({addr_switch, pfi_pin, bus_lost_pin, cable_absent_pin,
            open_pin}),
        .q({sw_s, pfi_s, lost_s, cab_s, open_s})
    );

    function automatic asc_val_t res_mask(input logic [2:0] code);
        logic [4:0] sh;
        sh = `ASC_RES_SHIFT0 - {1'b0, code, 1'b0};
        return `ASC_FULL_MASK << sh;
    endfunction : res_mask

    asc_scan_st_t st, next_st;
    logic [4:0] slot, next_slot;
    logic [27:0] tmo, next_tmo;
    asc_val_t offset, next_offset;
    asc_val_t cj_loc, next_cj_loc, cj_rem, next_cj_rem;
    asc_word_t wr_word, next_wr_word;
    logic wr_ok, next_wr_ok;
    logic next_fatal, powering, next_powering;
    logic next_start;
    logic [4:0] next_sel;
    logic [2:0] next_res_out;
    logic [2:0] res_tab [`ASC_NUM_CH];
    logic [2:0] next_res [`ASC_NUM_CH];
    logic [15:0] cfg_err, next_cfg_err;
    asc_word_t mem [`ASC_NUM_CH];
    asc_word_t next_rd_data;
    logic configured, next_configured;
    logic seen_exec, next_seen_exec;
    logic [3:0] chan;
    logic is_chan, is_rem;
    logic [2:0] cur_res;
    asc_val_t raw, corr, cj_add;

    assign chan = slot[3:0];
    assign is_chan = slot < `ASC_SLOT_REF;
    assign is_rem = cj_remote_en && (chan == cj_remote_chan);
    // References always run at full resolution for best calibration
    assign cur_res = is_chan ? res_tab[chan] : `ASC_RES_MAX;
    assign raw = adc_data & res_mask(cur_res);
    assign corr = raw - offset;
    // One junction value serves all thermocouples except the remote junction channel
    assign cj_add = (tc_mask[chan] && !is_rem)
        ? (cj_remote_en ? cj_rem : cj_loc) : '0;

    // Out-of-range codes clamp to full resolution and flag the channel
    for (genvar g = 0; g < `ASC_NUM_CH; g++)
    begin : g_res
        always_comb
        begin
            next_res[g] = res_tab[g];
            next_cfg_err[g] = cfg_err[g];
            if (res_wr_en && (res_wr_chan == 4'(g)))
            begin
                next_cfg_err[g] = res_wr_code > `ASC_RES_MAX;
                next_res[g] = next_cfg_err[g] ? `ASC_RES_MAX
                    : res_wr_code;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            res_tab <= '{default: `ASC_RES_RST};
            cfg_err <= '0;
        end
        else
        begin
            res_tab <= next_res;
            cfg_err <= next_cfg_err;
        end
    end

    always_comb
    begin
        next_st = st;
        next_slot = slot;
        next_tmo = tmo;
        next_offset = offset;
        next_cj_loc = cj_loc;
        next_cj_rem = cj_rem;
        next_wr_word = wr_word;
        next_wr_ok = wr_ok;
        next_fatal = fatal;
        next_powering = powering;
        next_start = 1'b0;
        next_sel = adc_sel;
        next_res_out = adc_res;
        unique case (st)
            SC_IDLE:
                next_st = SC_START;
            SC_START:
            begin
                next_start = 1'b1;
                next_sel = slot;
                next_res_out = cur_res;
                next_tmo = '0;
                next_wr_ok = 1'b0;
                next_st = SC_WAIT;
            end
            SC_WAIT:
            begin
                if (adc_done)
                begin
                    next_st = SC_WRITE;
                    if (slot == `ASC_SLOT_REF)
                    begin
                        next_offset = raw - `ASC_REF_NOM;
                        // Reference drift out of window is fatal
                        if (raw < `ASC_REF_LO || raw > `ASC_REF_HI)
                            next_fatal = 1'b1;
                        else
                            next_powering = 1'b0;
                    end
                    else if (slot == `ASC_SLOT_CJ)
                        next_cj_loc = corr;
                    else
                    begin
                        if (is_rem)
                            next_cj_rem = corr;
                        next_wr_ok = 1'b1;
                        next_wr_word = '0;
                        next_wr_word[23:0] = corr + cj_add;
                        next_wr_word[`ASC_ST_UNDER] =
                            raw < `ASC_UNDER_LIM;
                        next_wr_word[`ASC_ST_OVER] =
                            raw > `ASC_OVER_LIM;
                        next_wr_word[`ASC_ST_OPEN] =
                            open_s[chan] || cab_s;
                        next_wr_word[`ASC_ST_CFG] =
                            cfg_err[chan];
                    end
                end
                else if (tmo >= TMO_LIM)
                begin
                    // A stuck converter must not stall the scan
                    next_fatal = 1'b1;
                    next_st = SC_WRITE;
                end
                else
                    next_tmo = tmo + 28'h0000001;
            end
            SC_WRITE:
            begin
                next_slot = (slot == `ASC_SLOT_CJ) ? `ASC_SLOT_FIRST
                    : slot + 5'h01;
                next_st = SC_START;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st <= SC_IDLE;
            slot <= `ASC_SLOT_REF;
            tmo <= '0;
            offset <= '0;
            cj_loc <= '0;
            cj_rem <= '0;
            wr_word <= '0;
            wr_ok <= 1'b0;
            fatal <= 1'b0;
            powering <= 1'b1;
            adc_start <= 1'b0;
            adc_sel <= `ASC_SLOT_REF;
            adc_res <= `ASC_RES_MAX;
        end
        else
        begin
            st <= next_st;
            slot <= next_slot;
            tmo <= next_tmo;
            offset <= next_offset;
            cj_loc <= next_cj_loc;
            cj_rem <= next_cj_rem;
            wr_word <= next_wr_word;
            wr_ok <= next_wr_ok;
            fatal <= next_fatal;
            powering <= next_powering;
            adc_start <= next_start;
            adc_sel <= next_sel;
            adc_res <= next_res_out;
        end
    end

    // Read sees the old word if written the same cycle
    always_ff @(posedge core_clk)
    begin
        if (reset)
            mem <= '{default: '0};
        else if (st == SC_WRITE && wr_ok)
            mem[chan] <= wr_word;
    end

    always_comb
    begin
        next_rd_data = mem_rd_en ? mem[mem_rd_addr] : mem_rd_data;
        next_configured = configured || cfg_download;
        next_seen_exec = cfg_download ? 1'b0
            : (seen_exec || (configured && master_execute));
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            mem_rd_data <= '0;
            mem_rd_valid <= 1'b0;
            configured <= 1'b0;
            seen_exec <= 1'b0;
            slave_addr <= '0;
            diag_mode <= 1'b0;
        end
        else
        begin
            mem_rd_data <= next_rd_data;
            mem_rd_valid <= mem_rd_en;
            configured <= next_configured;
            seen_exec <= next_seen_exec;
            slave_addr <= sw_s;
            diag_mode <= sw_s == `ASC_DIAG_SW;
        end
    end

    asc_led_if li ();
    assign li.powering = powering;
    assign li.fatal = fatal;
    assign li.power_fail_interrupt_flag = pfi_s;
    assign li.cfgd = configured;
    assign li.cfg_mode = configured && seen_exec && !master_execute;
    assign li.lost = lost_s;
    assign li.diag = diag_mode;
    assign led_red = li.red;
    assign led_green = li.green;

    asc_led #(.BLINK_CYCLES(BLINK_CYCLES)) u_led (
        .core_clk(core_clk),
        .reset(reset),
        .li(li)
    );

    a_sel_range:
    assert property (@(posedge core_clk) disable iff (reset)
        adc_start |-> adc_sel <= `ASC_SLOT_CJ)
        else $error("selector slot out of range");
    a_res_legal:
    assert property (@(posedge core_clk) disable iff (reset)
        adc_res <= `ASC_RES_MAX)
        else $error("resolution code above 24 bits");
    a_res_applied:
    assert property (@(posedge core_clk) disable iff (reset)
        (adc_start && adc_sel < `ASC_SLOT_REF && !$past(res_wr_en))
        |-> adc_res == res_tab[adc_sel[3:0]])
        else $error("channel converted at wrong resolution");
    a_value_stored:
    assert property (@(posedge core_clk) disable iff (reset)
        (st == SC_WAIT && adc_done && is_chan) |=> st == SC_WRITE
        ##1 mem[$past(chan, 2)] == $past(wr_word))
        else $error("converted value not written to memory");
    a_open_flag:
    assert property (@(posedge core_clk) disable iff (reset)
        (st == SC_WAIT && adc_done && is_chan)
        |=> wr_word[`ASC_ST_OPEN] == $past(open_s[chan] || cab_s))
        else $error("open input flag wrong");
    a_cal_offset:
    assert property (@(posedge core_clk) disable iff (reset)
        (st == SC_WAIT && adc_done && slot == `ASC_SLOT_REF)
        |=> offset == $past(raw) - `ASC_REF_NOM)
        else $error("calibration offset not updated");
    a_ref_fatal:
    assert property (@(posedge core_clk) disable iff (reset)
        (st == SC_WAIT && adc_done && slot == `ASC_SLOT_REF
        && (raw < `ASC_REF_LO || raw > `ASC_REF_HI)) |=> fatal)
        else $error("bad reference not flagged fatal");
    a_read_port:
    assert property (@(posedge core_clk) disable iff (reset)
        mem_rd_en |=> mem_rd_valid
        && mem_rd_data == $past(mem[mem_rd_addr]))
        else $error("master read not served");
endmodule : asc_scan_top

// ==== shared/asc_regs.svh ====
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_NUM_CH 16
`define ASC_SLOT_REF 5'h10
`define ASC_SLOT_CJ 5'h11
`define ASC_SLOT_FIRST 5'h00
`define ASC_DIAG_SW 8'hFF
`define ASC_RES_MAX 3'h4
`define ASC_RES_RST 3'h0
`define ASC_RES_SHIFT0 5'h08
`define ASC_FULL_MASK 24'hFFFFFF
`define ASC_REF_NOM 24'h800000
`define ASC_REF_LO 24'h700000
`define ASC_REF_HI 24'h900000
`define ASC_UNDER_LIM 24'h000400
`define ASC_OVER_LIM 24'hFFF000
`define ASC_ST_UNDER 24
`define ASC_ST_OVER 25
`define ASC_ST_OPEN 26
`define ASC_ST_CFG 27
`define ASC_CLK_MHZ 100
`define ASC_US_PER_MS 1000
`define ASC_BLINK_MS 250
`define ASC_TMO_MS 2500
`define ASC_SYNC_W 27
`endif

// ==== shared/asc_pkg.sv ====
package asc_pkg;
    typedef logic [23:0] asc_val_t;
    typedef logic [31:0] asc_word_t;
    typedef enum logic [3:0] {
        SC_IDLE = 4'h1,
        SC_START = 4'h2,
        SC_WAIT = 4'h4,
        SC_WRITE = 4'h8
    } asc_scan_st_t;
    typedef enum logic [4:0] {
        LM_DARK = 5'h01,
        LM_GREEN = 5'h02,
        LM_GREEN_BLINK = 5'h04,
        LM_RED = 5'h08,
        LM_RED_FLASH = 5'h10
    } asc_led_mode_t;
endpackage : asc_pkg

// ==== shared/asc_led_if.sv ====
`timescale 1ns/1ps
interface asc_led_if;
    logic powering;
    logic fatal;
    logic power_fail_interrupt_flag;
    logic cfgd;
    logic cfg_mode;
    logic lost;
    logic diag;
    logic red;
    logic green;
    modport ctl (output powering, fatal, power_fail_interrupt_flag, cfgd, cfg_mode, lost, diag,
        input red, green);
    modport led (input powering, fatal, power_fail_interrupt_flag, cfgd, cfg_mode, lost, diag,
        output red, green);
endinterface : asc_led_if

// ==== hdl/asc_sync.sv ====
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_sync #(
    parameter int W = `ASC_SYNC_W
) (
    input wire logic core_clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic [W-1:0] d, // Asynchronous pins
    output logic [W-1:0] q // Synchronised copy
);
    logic [W-1:0] s1;
    logic [W-1:0] next_s1;
    logic [W-1:0] next_q;

    for (genvar g = 0; g < W; g++)
    begin : g_bit
        always_comb
        begin
            next_s1[g] = d[g];
            next_q[g] = s1[g];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s1 <= '0;
            q <= '0;
        end
        else
        begin
            s1 <= next_s1;
            q <= next_q;
        end
    end
endmodule : asc_sync

// ==== hdl/asc_led.sv ====
`timescale 1ns/1ps
module asc_led #(
    parameter int unsigned BLINK_CYCLES = 25000000
) (
    input wire logic core_clk, // System clock
    input wire logic reset, // Synchronous reset
    asc_led_if.led li // Status in, lamp out
);
    import asc_pkg::*;
    localparam logic [24:0] LIM = 25'(BLINK_CYCLES - 1);
    asc_led_mode_t mode, next_mode;
    logic [24:0] cnt, next_cnt;
    logic phase, next_phase, next_red, next_green;

    always_comb
    begin
        next_cnt = cnt + 25'h0000001;
        next_phase = phase;
        if (cnt >= LIM)
        begin
            next_cnt = '0;
            next_phase = !phase;
        end
        // Red faults outrank everything else
        if (li.power_fail_interrupt_flag || li.fatal)
            next_mode = LM_RED;
        else if (li.powering)
            next_mode = LM_RED_FLASH;
        else if (li.diag)
            next_mode = LM_GREEN;
        else if (li.lost || li.cfg_mode)
            next_mode = LM_GREEN_BLINK;
        else if (li.cfgd)
            next_mode = LM_GREEN;
        else
            next_mode = LM_DARK;
        next_red = (next_mode == LM_RED)
            || ((next_mode == LM_RED_FLASH) && phase);
        next_green = (next_mode == LM_GREEN)
            || ((next_mode == LM_GREEN_BLINK) && phase);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            mode <= LM_RED_FLASH;
            cnt <= '0;
            phase <= 1'b0;
            li.red <= 1'b0;
            li.green <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            cnt <= next_cnt;
            phase <= next_phase;
            li.red <= next_red;
            li.green <= next_green;
        end
    end

    a_pfi_red:
    assert property (@(posedge core_clk) disable iff (reset)
        li.power_fail_interrupt_flag |=> li.red && !li.green)
        else $error("power fail not shown steady red");
    a_fatal_red:
    assert property (@(posedge core_clk) disable iff (reset)
        li.fatal [*2] |=> li.red [*2])
        else $error("fatal failure not shown steady red");
    a_flash_nogreen:
    assert property (@(posedge core_clk) disable iff (reset)
        (li.powering && !li.power_fail_interrupt_flag && !li.fatal) |=> !li.green)
        else $error("green shown during power-up");
    a_dark_wait:
    assert property (@(posedge core_clk) disable iff (reset)
        !(li.power_fail_interrupt_flag || li.fatal || li.powering || li.diag || li.lost
        || li.cfg_mode || li.cfgd) |=> !li.red && !li.green)
        else $error("lamp lit while awaiting configuration");
    a_run_green:
    assert property (@(posedge core_clk) disable iff (reset)
        (li.cfgd && !li.cfg_mode && !li.lost && !li.power_fail_interrupt_flag && !li.fatal
        && !li.powering) |=> li.green && !li.red)
        else $error("running module not steady green");
endmodule : asc_led

// ==== tb/asc_adc_model.sv ====
`timescale 1ns/1ps
module asc_adc_model (
    input wire logic core_clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic adc_start, // Start pulse
    input wire logic [4:0] adc_sel, // Selected slot
    input wire logic [7:0] dly, // Conversion wait
    input wire logic mute, // Never answer
    output logic adc_done, // Result strobe
    output asc_pkg::asc_val_t adc_data // Result
);
    import asc_pkg::*;
    logic busy;
    logic [7:0] cnt;
    logic [4:0] slot;
    always_ff @(posedge core_clk)
    begin
        adc_done <= 1'b0;
        // Idle data lines toggle so a stale value cannot pass
        adc_data <= ~adc_data;
        if (reset)
        begin
            busy <= 1'b0;
            adc_data <= 24'h5A5A5A;
        end
        else if (adc_start)
        begin
            busy <= 1'b1;
            cnt <= dly;
            slot <= adc_sel;
        end
        else if (busy && !mute && cnt == 8'h00)
        begin
            busy <= 1'b0;
            adc_done <= 1'b1;
            case (slot)
                5'h10: adc_data <= 24'h800000;
                5'h11: adc_data <= 24'h003000;
                5'h03: adc_data <= 24'h000000;
                5'h05: adc_data <= 24'hFFF100;
                default: adc_data <= {4'h1, slot[3:0], 16'h0000};
            endcase
        end
        else if (busy && !mute)
            cnt <= cnt - 8'h01;
    end
endmodule : asc_adc_model

// ==== tb/tb_analog_slave_scan_status.sv ====
`timescale 1ns/1ps
module tb_analog_slave_scan_status;
    import asc_pkg::*;
    logic core_clk, reset, pfi_pin, bus_lost_pin, cable_absent_pin;
    logic cfg_download, master_execute, res_wr_en, cj_remote_en, mute;
    logic adc_done, adc_start, mem_rd_en, mem_rd_valid, diag_mode, fatal;
    logic led_red, led_green;
    logic [7:0] addr_switch, slave_addr, dly;
    logic [15:0] open_pin, tc_mask;
    logic [3:0] res_wr_chan, cj_remote_chan, mem_rd_addr;
    logic [2:0] res_wr_code, adc_res;
    logic [4:0] adc_sel;
    asc_val_t adc_data;
    asc_word_t mem_rd_data;
    int errors = 0;
    int checked = 0;

    asc_scan_top #(.BLINK_CYCLES(4), .TMO_CYCLES(50)) asc_scan_top_inst (
        .core_clk(core_clk), .reset(reset), .addr_switch(addr_switch),
        .pfi_pin(pfi_pin), .bus_lost_pin(bus_lost_pin),
        .cable_absent_pin(cable_absent_pin), .open_pin(open_pin),
        .cfg_download(cfg_download), .master_execute(master_execute),
        .res_wr_en(res_wr_en), .res_wr_chan(res_wr_chan),
        .res_wr_code(res_wr_code), .tc_mask(tc_mask),
        .cj_remote_en(cj_remote_en), .cj_remote_chan(cj_remote_chan),
        .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start),
        .adc_sel(adc_sel), .adc_res(adc_res), .mem_rd_en(mem_rd_en),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
        .mem_rd_valid(mem_rd_valid), .slave_addr(slave_addr),
        .diag_mode(diag_mode), .fatal(fatal), .led_red(led_red),
        .led_green(led_green));

    asc_adc_model asc_adc_model_inst (
        .core_clk(core_clk), .reset(reset), .adc_start(adc_start),
        .adc_sel(adc_sel), .dly(dly), .mute(mute), .adc_done(adc_done),
        .adc_data(adc_data));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task complete_run;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    // Codes: 0 dark, 1 green, 2 green blink, 3 red, 4 mixed, 5 red flash
    task automatic lamp(input logic [2:0] exp);
        int r;
        int g;
        logic [2:0] got;
        r = 0;
        g = 0;
        repeat (12)
        begin
            @(negedge core_clk);
            r += int'(led_red === 1'b1);
            g += int'(led_green === 1'b1);
        end
        if (g == 0)
            got = (r == 0) ? 3'h0 : (r == 12) ? 3'h3 : 3'h5;
        else
            got = (r != 0) ? 3'h4 : (g == 12) ? 3'h1 : 3'h2;
        chk({29'h0, got}, {29'h0, exp});
        // Hand back on a rising edge so callers drive inputs there
        @(posedge core_clk);
    endtask : lamp

    task automatic wait_start;
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end while (adc_start !== 1'b1 && n < 100);
        chk({31'h0, adc_start}, 32'h1);
    endtask : wait_start

    task automatic wait_slot(input logic [4:0] s);
        int n;
        n = 0;
        do
        begin
            wait_start();
            n++;
        end while (adc_sel !== s && n < 30);
        chk({27'h0, adc_sel}, {27'h0, s});
    endtask : wait_slot

    function automatic logic [2:0] res_exp(input int ch);
        return (ch == 9) ? 3'h4 : 3'(ch % 5);
    endfunction : res_exp

    function automatic asc_word_t exp_word(input int ch, input logic cab);
        asc_val_t v;
        case (ch)
            // Cable pass also uses channel 4 as remote junction
            2: v = cab ? 24'h260000 : 24'h123000;
            3: v = 24'h000000;
            5: v = 24'hFFF100;
            default: v = {4'h1, 4'(ch), 16'h0000};
        endcase
        return {4'h0, ch == 9, cab | (ch == 7), ch == 5, ch == 3, v};
    endfunction : exp_word

    // Reads run back to back while the scan keeps writing
    task automatic read_all(input logic cab);
        for (int i = 0; i <= 16; i++)
        begin
            @(posedge core_clk);
            mem_rd_en <= (i < 16);
            mem_rd_addr <= 4'(i);
            if (i > 0)
            begin
                @(negedge core_clk);
                chk({31'h0, mem_rd_valid}, 32'h1);
                chk(mem_rd_data, exp_word(i - 1, cab));
            end
        end
        @(posedge core_clk);
    endtask : read_all

    task automatic pulse_cfg;
        @(posedge core_clk);
        cfg_download <= 1'b1;
        @(posedge core_clk);
        cfg_download <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask : pulse_cfg

    task automatic t_power;
        @(negedge core_clk);
        chk({24'h0, adc_sel, adc_res}, {24'h0, 5'h10, 3'h4});
        lamp(3'h5);
        chk({24'h0, slave_addr}, 32'h5A);
        chk({31'h0, diag_mode}, 32'h0);
        repeat (40) @(posedge core_clk);
        lamp(3'h0);
        dly <= 8'h02;
    endtask : t_power

    task automatic t_scan;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge core_clk);
            res_wr_en <= 1'b1;
            res_wr_chan <= 4'(i);
            res_wr_code <= (i == 9) ? 3'h7 : 3'(i % 5);
        end
        @(posedge core_clk);
        res_wr_en <= 1'b0;
        wait_slot(5'h10);
        for (int k = 1; k < 18; k++)
        begin
            wait_start();
            chk({24'h0, adc_sel, adc_res}, (k == 1) ? 32'h8C :
                {24'h0, 5'(k - 2), res_exp(k - 2)});
        end
        wait_slot(5'h10);
        repeat (3) @(posedge core_clk);
        read_all(1'b0);
    endtask : t_scan

    task automatic t_cable;
        cable_absent_pin <= 1'b1;
        cj_remote_en <= 1'b1;
        cj_remote_chan <= 4'h4;
        // Remote junction needs one full scan before channel 2 uses it
        repeat (3) wait_slot(5'h10);
        repeat (3) @(posedge core_clk);
        read_all(1'b1);
        cable_absent_pin <= 1'b0;
        cj_remote_en <= 1'b0;
    endtask : t_cable

    task automatic t_lamp;
        pulse_cfg();
        lamp(3'h1);
        master_execute <= 1'b1;
        repeat (5) @(posedge core_clk);
        lamp(3'h1);
        master_execute <= 1'b0;
        repeat (5) @(posedge core_clk);
        lamp(3'h2);
        pulse_cfg();
        bus_lost_pin <= 1'b1;
        repeat (5) @(posedge core_clk);
        lamp(3'h2);
        pfi_pin <= 1'b1;
        repeat (5) @(posedge core_clk);
        lamp(3'h3);
        pfi_pin <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask : t_lamp

    task automatic t_diag;
        addr_switch <= 8'hFF;
        repeat (6) @(posedge core_clk);
        chk({31'h0, diag_mode}, 32'h1);
        lamp(3'h1);
        addr_switch <= 8'hA5;
        bus_lost_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk({24'h0, slave_addr}, 32'hA5);
    endtask : t_diag

    task automatic t_fatal;
        int n;
        n = 0;
        mute <= 1'b1;
        do
        begin
            @(negedge core_clk);
            n++;
        end while (fatal !== 1'b1 && n < 300);
        chk({31'h0, fatal}, 32'h1);
        lamp(3'h3);
    endtask : t_fatal

    initial
    begin
        reset = 1'b1;
        {pfi_pin, bus_lost_pin, cable_absent_pin, mute} = 4'h0;
        {cfg_download, master_execute, res_wr_en, cj_remote_en} = 4'h0;
        {res_wr_chan, res_wr_code, cj_remote_chan} = 11'h000;
        {mem_rd_en, mem_rd_addr} = 5'h00;
        addr_switch = 8'h5A;
        open_pin = 16'h0080;
        tc_mask = 16'h0004;
        dly = 8'h14;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        t_power();
        t_scan();
        t_cable();
        t_lamp();
        t_diag();
        t_fatal();
        complete_run();
    end

    initial
    begin
        #200000;
        errors++;
        complete_run();
    end
endmodule : tb_analog_slave_scan_status
